// ===== core/pct_pkg.sv
// constants for the pressure-change threshold register bank
package pct_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_BASE = 8'h58;
	localparam logic [7:0] OFS_DEB  = 8'h58;
	localparam logic [7:0] OFS_FIXH = 8'h59;
	localparam logic [7:0] OFS_FIXL = 8'h5a;
	localparam logic [7:0] OFS_MIN  = 8'h5b;
	localparam logic [7:0] OFS_RELH = 8'h5c;
	localparam logic [7:0] OFS_RELL = 8'h5d;
	localparam logic [7:0] OFS_SLPH = 8'h5e;
	localparam logic [7:0] OFS_SLPL = 8'h5f;
	localparam int         NUM_REGS = 8;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_DEB  = 8'h05;
	localparam logic [7:0] RST_FIXH = 8'h03;
	localparam logic [7:0] RST_FIXL = 8'h20;
	localparam logic [7:0] RST_MIN  = 8'h03;
	localparam logic [7:0] RST_RELH = 8'h00;
	localparam logic [7:0] RST_RELL = 8'h32;
	localparam logic [7:0] RST_SLPH = 8'h00;
	localparam logic [7:0] RST_SLPL = 8'h40;

	// ****************************************
	// field values and scaling
	// ****************************************
	localparam logic [7:0] DEB_BAD   = 8'hff;
	localparam logic [7:0] DEB_MAX   = 8'hfe;
	localparam int         SLOPE_SHL = 7;
	localparam logic [7:0] RUN_MAX   = 8'hfe;

endpackage : pct_pkg

// ===== core/pct_deb_if.sv
// debounce counter hookup between the checks and their counters
`timescale 1ns/100ps
interface pct_deb_if;
	logic       sample;
	logic       qual;
	logic [7:0] limit;
	logic       reached;

	modport core (output sample, output qual, output limit, input reached);
	modport deb  (input sample, input qual, input limit, output reached);
endinterface : pct_deb_if

// ===== core/pct_debounce.sv
// consecutive-sample debounce counter for one pressure-change check
`timescale 1ns/100ps
module pct_debounce (
	input  wire logic clk,
	input  wire logic nrst,
	pct_deb_if.deb    d
);

	logic [7:0] cnt_q;
	logic [8:0] cnt_inc;

	// count including the sample now arriving
	assign cnt_inc = {1'b0, cnt_q} + 9'h001;

	// ****************************************
	// consecutive qualifying samples
	// ****************************************
	// restart on any miss
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00;
		end else if (d.sample) begin
			if (!d.qual)
				cnt_q <= 8'h00;
			else if (cnt_q != 8'hff)
				cnt_q <= cnt_inc[7:0];
		end
	end

	assign d.reached = d.sample && d.qual && (cnt_inc >= {1'b0, d.limit});

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	miss_clears_a: assert property (d.sample && !d.qual |=> cnt_q == 8'h00)
		else $error("debounce count not restarted on a miss");
	// first qualifying sample of a run counts as one, so a limit above one holds it off
	early_hold_a: assert property (
		d.sample && d.qual && cnt_q == 8'h00 && d.limit > 8'h01 |-> !d.reached)
		else $error("condition declared before debounce count reached");

endmodule : pct_debounce

// ===== core/pct_threshold_regs.sv
// pressure-change threshold registers and the three wake-up checks
//
// What this block does
// - The debounce count limit is the least run of qualifying samples before the fixed-level or relative-rise check fires.
// - A debounce count limit of 255 left by the host becomes 254 when transfers complete.
// - The debounce count limit is a read/write byte at 0x58 resetting to 0x05.
// - With its enable set, the fixed-level flag rises when pressure stays above the limit.
// - The fixed level limit is bytes 0x59 (high, 0x03) and 0x5a (low, 0x20), read/write.
// - Pressure counts as rising only when a sample beats the last by the minimum step.
// - The minimum rise step is a read/write byte at 0x5b resetting to 0x03.
// - With its enable set, the relative-rise flag rises when the rise stays above its limit.
// - The relative rise limit is bytes 0x5c (high, 0x00) and 0x5d (low, 0x32), read/write.
// - The rise-rate limit is bytes 0x5e (high, 0x00) and 0x5f (low, 0x40), read/write.
// - With its enable set, the slope flag rises when the computed slope beats the limit.
// - The slope is the rise times 128 over one plus the rising sampling periods.
`timescale 1ns/100ps
module pct_threshold_regs (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        xfer_done,
	input  wire logic        smp_valid,
	input  wire logic [15:0] smp_pressure,
	input  wire logic        fixed_level_check_enable,
	input  wire logic        relative_rise_check_enable,
	input  wire logic        slope_check_enable,
	input  wire logic        flag_clear,
	output logic             fixed_level_flag,
	output logic             relative_rise_flag,
	output logic             slope_flag
);

	// ****************************************
	// helper functions
	// ****************************************

	// true when the address falls inside this bank
	function automatic logic in_bank(input logic [7:0] a);
		in_bank = (a >= pct_pkg::OFS_BASE) &&
			(a < pct_pkg::OFS_BASE + 8'(pct_pkg::NUM_REGS));
	endfunction : in_bank

	// register index for an address inside the bank
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		logic [7:0] off;
		off = a - pct_pkg::OFS_BASE;
		reg_idx = off[2:0];
	endfunction : reg_idx

	// rise of a over b, zero when not above
	function automatic logic [15:0] rise_of(input logic [15:0] a,
		input logic [15:0] b);
		rise_of = (a > b) ? (a - b) : 16'h0000;
	endfunction : rise_of

	// ****************************************
	// register storage
	// ****************************************
	logic [7:0] regs_q [pct_pkg::NUM_REGS];
	logic [7:0] rdata_q;
	logic       wr_hit;
	logic [2:0] wr_idx;

	// reset image, in index order
	localparam logic [7:0] RST_IMG [pct_pkg::NUM_REGS] = '{
		pct_pkg::RST_DEB,  pct_pkg::RST_FIXH,
		pct_pkg::RST_FIXL, pct_pkg::RST_MIN,
		pct_pkg::RST_RELH, pct_pkg::RST_RELL,
		pct_pkg::RST_SLPH, pct_pkg::RST_SLPL
	};

	localparam logic [2:0] IDX_DEB  = 3'h0;
	localparam logic [2:0] IDX_FIXH = 3'h1;
	localparam logic [2:0] IDX_FIXL = 3'h2;
	localparam logic [2:0] IDX_MIN  = 3'h3;
	localparam logic [2:0] IDX_RELH = 3'h4;
	localparam logic [2:0] IDX_RELL = 3'h5;
	localparam logic [2:0] IDX_SLPH = 3'h6;
	localparam logic [2:0] IDX_SLPL = 3'h7;

	// write decode
	assign wr_hit = reg_wr && in_bank(reg_addr);
	assign wr_idx = reg_idx(reg_addr);

	// ****************************************
	// host writes and debounce clamp
	// ****************************************
	// bank writes, reset image
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regs_q <= RST_IMG;
		end else if (wr_hit) begin
			regs_q[wr_idx] <= reg_wdata;
		end else if (xfer_done && regs_q[IDX_DEB] == pct_pkg::DEB_BAD) begin
			regs_q[IDX_DEB] <= pct_pkg::DEB_MAX;
		end
	end

	// ****************************************
	// host reads
	// ****************************************
	// read data held until next read; unmapped reads zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			rdata_q <= in_bank(reg_addr) ? regs_q[reg_idx(reg_addr)] : 8'h00;
		end
	end

	assign reg_rdata = rdata_q;

	// ****************************************
	// assembled limits
	// ****************************************
	logic [7:0]  deb_limit;
	logic [15:0] fix_limit;
	logic [7:0]  min_step;
	logic [15:0] rel_limit;
	logic [15:0] slp_limit;

	assign fix_limit = {regs_q[IDX_FIXH], regs_q[IDX_FIXL]};
	assign rel_limit = {regs_q[IDX_RELH], regs_q[IDX_RELL]};
	assign slp_limit = {regs_q[IDX_SLPH], regs_q[IDX_SLPL]};
	assign min_step  = regs_q[IDX_MIN];
	assign deb_limit = regs_q[IDX_DEB];

	// ****************************************
	// rise tracking
	// ****************************************
	logic [15:0] prev_q;
	logic        have_prev_q;
	logic [15:0] base_q;
	logic [7:0]  run_q;
	logic [15:0] step;
	logic        inc;
	logic [15:0] rise_now;

	// step over the previous sample
	assign step = rise_of(smp_pressure, prev_q);

	// rising only by the minimum step
	assign inc = have_prev_q && (smp_pressure > prev_q) && (step >= {8'h00, min_step});

	// total rise since the run began
	assign rise_now = rise_of(smp_pressure, base_q);

	// previous sample, kept for the next comparison
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_q      <= 16'h0000;
			have_prev_q <= 1'b0;
		end else if (smp_valid) begin
			prev_q      <= smp_pressure;
			have_prev_q <= 1'b1;
		end
	end

	// run start and length; a non-rising sample starts afresh
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			base_q <= 16'h0000;
			run_q  <= 8'h00;
		end else if (smp_valid) begin
			if (!inc) begin
				base_q <= smp_pressure;
				run_q  <= 8'h00;
			end else if (run_q != pct_pkg::RUN_MAX) begin
				run_q <= run_q + 8'h01;
			end
		end
	end

	// ****************************************
	// slope
	// ****************************************
	logic [22:0] slope_num;
	logic [8:0]  slope_den;
	logic [22:0] slope_val;

	// rise x 128 over periods + 1
	assign slope_num = {rise_now, 7'h00};
	assign slope_den = {1'b0, run_q} + 9'h002;
	assign slope_val = slope_num / {14'h0000, slope_den};

	// ****************************************
	// debounced checks
	// ****************************************
	pct_deb_if fix_if ();
	pct_deb_if rel_if ();

	assign fix_if.sample = smp_valid;
	assign fix_if.qual   = fixed_level_check_enable && (smp_pressure > fix_limit);
	assign fix_if.limit  = deb_limit;

	assign rel_if.sample = smp_valid;
	assign rel_if.qual   = relative_rise_check_enable && inc && (rise_now > rel_limit);
	assign rel_if.limit  = deb_limit;

	pct_debounce u_fix_deb (
		.clk  (clk),
		.nrst (nrst),
		.d    (fix_if.deb)
	);

	pct_debounce u_rel_deb (
		.clk  (clk),
		.nrst (nrst),
		.d    (rel_if.deb)
	);

	// ****************************************
	// status flags
	// ****************************************
	logic fix_flag_q;
	logic rel_flag_q;
	logic slp_flag_q;
	logic slp_hit;

	assign slp_hit = smp_valid && slope_check_enable && inc &&
		(slope_val > {7'h00, slp_limit});

	// sticky flags; a new event wins over a clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fix_flag_q <= 1'b0;
			rel_flag_q <= 1'b0;
			slp_flag_q <= 1'b0;
		end else begin
			fix_flag_q <= fix_if.reached || (fix_flag_q && !flag_clear);
			rel_flag_q <= rel_if.reached || (rel_flag_q && !flag_clear);
			slp_flag_q <= slp_hit || (slp_flag_q && !flag_clear);
		end
	end

	assign fixed_level_flag   = fix_flag_q;
	assign relative_rise_flag = rel_flag_q;
	assign slope_flag         = slp_flag_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// host writes a byte, then reads it back
	sequence wr_deb_s;
		reg_wr && reg_addr == pct_pkg::OFS_DEB;
	endsequence

	sequence rd_deb_s;
		reg_rd && !reg_wr && reg_addr == pct_pkg::OFS_DEB;
	endsequence

	// a quiet cycle between write and read keeps the clamp and other writes out
	deb_readback_a: assert property (
		wr_deb_s ##1 (!reg_wr && !xfer_done) ##1 rd_deb_s |=> reg_rdata == $past(reg_wdata, 3))
		else $error("debounce limit read back wrong");

	deb_clamp_a: assert property (
		xfer_done && !reg_wr && deb_limit == pct_pkg::DEB_BAD
		|=> deb_limit == pct_pkg::DEB_MAX)
		else $error("debounce limit 255 not clamped to 254");

	fix_high_a: assert property (
		reg_rd && reg_addr == pct_pkg::OFS_FIXH |=> reg_rdata == $past(fix_limit[15:8]))
		else $error("fixed level high byte read wrong");

	min_read_a: assert property (
		reg_rd && reg_addr == pct_pkg::OFS_MIN |=> reg_rdata == $past(min_step))
		else $error("minimum step read wrong");

	fix_cause_a: assert property (
		$rose(fixed_level_flag) |-> $past(smp_valid && fixed_level_check_enable &&
		smp_pressure > fix_limit))
		else $error("fixed level flag without cause");

	not_rising_a: assert property (
		smp_valid && have_prev_q && smp_pressure <= prev_q |=> run_q == 8'h00)
		else $error("run kept on a non-rising sample");

	rel_cause_a: assert property (
		$rose(relative_rise_flag) |-> $past(relative_rise_check_enable && inc))
		else $error("relative rise flag without rising sample");

	slope_off_a: assert property (
		!slope_check_enable && !slope_flag |=> !slope_flag)
		else $error("slope flag set while check disabled");

	flag_keep_a: assert property (
		slope_flag && !flag_clear |=> slope_flag)
		else $error("slope flag dropped without clear");

endmodule : pct_threshold_regs

// ===== verif/pct_host_model.sv
// host-side register access model for the threshold bank
`timescale 1ns/100ps
module pct_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	output logic            xfer_done
);
	// ****************************************
	// idle bus
	// ****************************************
	// everything quiet at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		xfer_done = 1'b0;
	end

	// ****************************************
	// access tasks
	// ****************************************
	// one byte write, data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr

	// one byte read, data taken a cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd

	// end of one transfer sequence
	task automatic done;
		@(negedge clk);
		xfer_done = 1'b1;
		@(negedge clk);
		xfer_done = 1'b0;
	endtask : done

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 8'h01, v[7:0]);
		done();
	endtask : wr16
endmodule : pct_host_model

// ===== verif/tb_pct_threshold_regs.sv
// self-checking bench for the pressure-change threshold bank
`timescale 1ns/100ps
module tb_pct_threshold_regs;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
	logic        reg_wr, reg_rd, xfer_done;
	logic        smp_valid = 1'b0;
	logic        flag_clear = 1'b0;
	logic [15:0] smp_pressure = 16'h0000;
	logic        fixed_level_check_enable = 1'b0;
	logic        relative_rise_check_enable = 1'b0;
	logic        slope_check_enable = 1'b0;
	logic        fixed_level_flag, relative_rise_flag, slope_flag;
	int          n_fail = 0;
	int          total_checks = 0;
	int          seed = 79409;
	logic [7:0]  rnd [8];
	localparam logic [7:0] RST_V [8] = '{8'h05, 8'h03, 8'h20, 8'h03, 8'h00, 8'h32, 8'h00, 8'h40};

	// 100 ns clock
	always #50 clk = ~clk;

	pct_threshold_regs u_dut (.clk, .nrst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
		.xfer_done, .smp_valid, .smp_pressure, .fixed_level_check_enable,
		.relative_rise_check_enable, .slope_check_enable, .flag_clear,
		.fixed_level_flag, .relative_rise_flag, .slope_flag);

	pct_host_model u_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .xfer_done);

	// ****************************************
	// helpers
	// ****************************************
	// expected slope for a rise over a number of rising periods
	function automatic int slope_of(input int rise, input int periods);
		return rise * 128 / (periods + 1);
	endfunction : slope_of

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, rv);
		chk({8'h00, rv}, {8'h00, e});
	endtask : rchk

	// one sample pulse, then a cycle for the flag to land
	task automatic smp(input logic [15:0] p);
		@(negedge clk);
		smp_valid = 1'b1;
		smp_pressure = p;
		@(negedge clk);
		smp_valid = 1'b0;
		smp_pressure = ~p;
		@(negedge clk);
	endtask : smp

	task automatic fclr;
		@(negedge clk);
		flag_clear = 1'b1;
		@(negedge clk);
		flag_clear = 1'b0;
	endtask : fclr

	task automatic fchk(input logic [2:0] e);
		chk({13'h0000, fixed_level_flag, relative_rise_flag, slope_flag}, {13'h0000, e});
	endtask : fchk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// ****************************************
	// tests
	// ****************************************
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk) nrst = 1'b1;
		for (int i = 0; i < 8; i++) rchk(8'h58 + i[7:0], RST_V[i]);
		u_host.wr(8'h60, 8'h5a);
		u_host.done();
		rchk(8'h60, 8'h00);
		rchk(8'h57, 8'h00);
		$display("test reset_image done");
		for (int i = 0; i < 8; i++) begin
			rnd[i] = 8'($random(seed));
			if (i == 0 && rnd[0] == 8'hff) rnd[0] = 8'h7f;
			u_host.wr(8'h58 + i[7:0], rnd[i]);
		end
		u_host.done();
		for (int i = 0; i < 8; i++) rchk(8'h58 + i[7:0], rnd[i]);
		$display("test readback done");
		u_host.wr(8'h58, 8'hff);
		rchk(8'h58, 8'hff);
		u_host.done();
		rchk(8'h58, 8'hfe);
		u_host.wr(8'h58, 8'hfe);
		u_host.done();
		rchk(8'h58, 8'hfe);
		$display("test clamp done");
		// run of three with a miss in between
		u_host.wr(8'h58, 8'h03);
		u_host.wr16(8'h59, 16'h0400);
		fclr();
		fixed_level_check_enable = 1'b1;
		smp(16'h0401);
		smp(16'h0401);
		smp(16'h0400);
		smp(16'h0401);
		smp(16'h0401);
		fchk(3'b000);
		smp(16'h0401);
		fchk(3'b100);
		fclr();
		fchk(3'b000);
		fixed_level_check_enable = 1'b0;
		for (int i = 0; i < 6; i++) smp(16'h8000 | 16'($random(seed)));
		fchk(3'b000);
		$display("test fixed_level done");
		// small step is not a rise and moves the base
		u_host.wr(8'h58, 8'h01);
		u_host.wr(8'h5b, 8'h03);
		u_host.wr16(8'h5c, 16'd11);
		relative_rise_check_enable = 1'b1;
		fclr();
		smp(16'd1000);
		smp(16'd1002);
		smp(16'd1012);
		fchk(3'b000);
		smp(16'd1015);
		fchk(3'b010);
		relative_rise_check_enable = 1'b0;
		$display("test relative_rise done");
		// slope divisor counts the rising periods
		u_host.wr16(8'h5e, 16'd640);
		slope_check_enable = 1'b1;
		fclr();
		smp(16'd1000);
		smp(16'd1010);
		fchk({2'b00, slope_of(10, 1) > 640});
		smp(16'd1020);
		fchk({2'b00, slope_of(20, 2) > 640});
		slope_check_enable = 1'b0;
		$display("test slope done");
		// mid-run reset clears flags and restores the reset image
		@(negedge clk) nrst = 1'b0;
		@(negedge clk) nrst = 1'b1;
		fchk(3'b000);
		rchk(8'h58, 8'h05);
		rchk(8'h5f, 8'h40);
		$display("test mid_reset done");
		tally_and_finish();
	end

	// watchdog against a hang
	initial begin
		#400000;
		n_fail++;
		tally_and_finish();
	end
endmodule : tb_pct_threshold_regs
